// ===== scm_pkg.sv
package scm_pkg;

	// Register bus widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [15:0] ADDR_CTRL1     = 16'h0120;
	localparam logic [15:0] ADDR_CTRL2     = 16'h0121;
	localparam logic [15:0] ADDR_CTRL3     = 16'h0122;
	localparam logic [15:0] ADDR_TS_DELAY  = 16'h0123;
	localparam logic [15:0] ADDR_STATUS1   = 16'h0128;
	localparam logic [15:0] ADDR_STATUS2   = 16'h0129;
	localparam logic [15:0] ADDR_COUNT     = 16'h012A;
	localparam logic [15:0] ADDR_SYNC_MODE = 16'h01FF;
	localparam logic [15:0] ADDR_IRQ_STAT  = 16'h0130;
	localparam logic [15:0] ADDR_IRQ_MASK  = 16'h0131;

	// Control and sync field positions and writable bits
	localparam int unsigned CTRL1_FLAG_RST_BIT = 6;
	localparam int unsigned CTRL1_EDGE_SEL_BIT = 4;
	localparam int unsigned CTRL1_CLK_EDGE_BIT = 3;
	localparam int unsigned CTRL1_MODE_LSB     = 1;
	localparam logic [7:0]  CTRL1_WR_MASK      = 8'h5E;
	localparam logic [7:0]  CTRL2_WR_MASK      = 8'h0F;
	localparam logic [7:0]  CTRL3_WR_MASK      = 8'h0F;
	localparam logic [7:0]  TS_DELAY_WR_MASK   = 8'h7F;
	localparam logic [7:0]  SYNC_WR_MASK       = 8'h01;
	localparam int unsigned CTRL3_WIN_POS_LSB  = 0;
	localparam int unsigned SYNC_MODE_BIT      = 0;

	// Capture mode codes
	localparam logic [1:0] MODE_DISABLED = 2'h0;
	localparam logic [1:0] MODE_CONT     = 2'h1;
	localparam logic [1:0] MODE_NSHOT    = 2'h2;

	// Synchronization mode codes
	localparam logic SYNC_DIV_RESET = 1'b0;
	localparam logic SYNC_TIMESTAMP = 1'b1;

	// Reset, lateness and phase reference values
	localparam logic [7:0] REG_RST     = 8'h00;
	localparam logic [2:0] LATE_SAT    = 3'h4;
	localparam logic [2:0] LATE_FIRST  = 3'h1;
	localparam logic [3:0] PHASE_ZERO  = 4'h0;

	// Interrupt status bits
	localparam int unsigned IRQ_W        = 3;
	localparam int unsigned IRQ_CAP_BIT  = 0;
	localparam int unsigned IRQ_MISS_BIT = 1;
	localparam int unsigned IRQ_LINK_BIT = 2;

	// N-shot sequencing states
	typedef enum logic {SCM_NS_WAIT, SCM_NS_DONE} scm_nshot_e;

endpackage : scm_pkg

// ===== scm_cap_if.sv
`timescale 1ns/1ps
interface scm_cap_if;
	logic cap;
	logic miss;
	logic [2:0] lateness;

	// Edge qualifier drives, top consumes
	modport src (output cap, output miss, output lateness);
	modport snk (input cap, input miss, input lateness);
endinterface : scm_cap_if

// ===== scm_ts_delay.sv
`timescale 1ns/1ps
module scm_ts_delay
#(
	parameter int unsigned DLY_W = 7
)
(
	input  wire logic             core_clk_i, // Sample clock
	input  wire logic             rstn_i,     // Sync reset, low
	input  wire logic             start_i,    // Capture strobe
	input  wire logic [DLY_W-1:0] delay_i,    // Delay in cycles
	output logic                  fire_o      // Timestamp pulse
);

	logic [DLY_W-1:0] cnt_r;
	logic             busy_r;

	// Countdown; a new start restarts the delay
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			fire_o <= 1'b0;
		end
		else if (start_i)
		begin
			cnt_r  <= delay_i - 1'b1;
			busy_r <= (delay_i != '0);
			fire_o <= (delay_i == '0);
		end
		else
		begin
			cnt_r  <= cnt_r - 1'b1;
			busy_r <= busy_r && (cnt_r != '0);
			fire_o <= busy_r && (cnt_r == '0);
		end
	end

	// Zero delay fires on the next edge
	property p_zero_delay;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(start_i && delay_i == '0) |=> fire_o;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not fire");

endmodule : scm_ts_delay

// ===== scm_sysref_edge.sv
`timescale 1ns/1ps
module scm_sysref_edge
(
	input  wire logic       core_clk_i, // Sample clock
	input  wire logic       rstn_i,     // Sync reset, low
	input  wire logic       sysref_i,   // Alignment pulse level
	input  wire logic       align_i,    // Expected capture instant
	input  wire logic       fall_sel_i, // Use high to low edge
	input  wire logic [1:0] mode_i,     // Capture mode
	input  wire logic [1:0] window_i,   // Positive skew window
	input  wire logic [3:0] ignore_i,   // N-shot ignore count
	input  wire logic       rearm_i,    // Restart N-shot
	scm_cap_if.src          cap_if      // Capture events
);

	logic                sref_d_r;
	logic [2:0]          late_r;
	logic [3:0]          ign_r;
	scm_pkg::scm_nshot_e ns_r;
	logic                cap_r;
	logic                miss_r;

	// Edge detection and window qualification
	wire logic       raw_edge = fall_sel_i ? (sref_d_r & ~sysref_i) : (sysref_i & ~sref_d_r);
	wire logic [2:0] lateness = align_i ? 3'h0 : late_r;
	wire logic       in_win   = (lateness <= {1'b0, window_i});
	wire logic       cont     = (mode_i == scm_pkg::MODE_CONT);
	wire logic       nshot    = (mode_i == scm_pkg::MODE_NSHOT);
	wire logic       ns_wait  = nshot && (ns_r == scm_pkg::SCM_NS_WAIT);
	wire logic       ns_skip  = ns_wait && (ign_r < ignore_i);
	wire logic       eligible = raw_edge && (cont || (ns_wait && !ns_skip));
	wire logic       take     = eligible && in_win;

	assign cap_if.cap      = cap_r;
	assign cap_if.miss     = miss_r;
	assign cap_if.lateness = late_r;

	// Lateness counter and output pulses
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			sref_d_r <= 1'b0;
			late_r   <= scm_pkg::LATE_SAT;
			cap_r    <= 1'b0;
			miss_r   <= 1'b0;
		end
		else
		begin
			sref_d_r <= sysref_i;
			late_r   <= align_i ? scm_pkg::LATE_FIRST :
			            (late_r < scm_pkg::LATE_SAT) ? late_r + 3'h1 : late_r;
			cap_r    <= take;
			miss_r   <= eligible && !in_win;
		end
	end

	// N-shot ignore count and one-shot state
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i || rearm_i)
		begin
			ign_r <= 4'h0;
			ns_r  <= scm_pkg::SCM_NS_WAIT;
		end
		else
		begin
			if (raw_edge && ns_skip)
				ign_r <= ign_r + 4'h1;
			if (take && nshot)
				ns_r <= scm_pkg::SCM_NS_DONE;
		end
	end

	property p_exact_window;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(raw_edge && cont && window_i == 2'h0 && !align_i) |=> !cap_if.cap;
	endproperty
	a_exact_window: assert property (p_exact_window) else $error("late capture accepted");

	property p_late_three;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(raw_edge && cont && window_i == 2'h3 && lateness == 3'h3) |=> cap_if.cap;
	endproperty
	a_late_three: assert property (p_late_three) else $error("in-window capture lost");

	property p_nshot_skip;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(raw_edge && ns_skip && !rearm_i) |=> (!cap_if.cap && ign_r == $past(ign_r) + 4'h1);
	endproperty
	a_nshot_skip: assert property (p_nshot_skip) else $error("ignored edge acted on");

endmodule : scm_sysref_edge

// ===== sysref_capture_monitor.sv
`timescale 1ns/1ps
// Behaviour
// - Positive skew window codes 0..3 accept captures up to that many cycles late.
// - Timestamp output delayed by the seven-bit programmed count, 0 to 127 cycles.
// - Hold status at bits 7:4, setup status at bits 3:0, read-only.
// - Each capture records the four-bit divider phase, half input cycle per step.
// - Eight-bit capture counter increments per captured event, wraps after 255.
// - Flag-reset bit six of control 1 clears the capture counter.
// - Divider-reset mode: each capture resets every internal clock divider.
// - Divider-reset mode: capture that shifts divider phase takes the link down.
// - Timestamp mode: capture leaves dividers, link and signal monitor untouched.
// - Timestamp mode: capture marks the sample then in the data path.
// - Flag-reset bit high holds setup and hold flags cleared; low runs normally.
// - N-shot skips the programmed number of transitions, then acts on next.
module sysref_capture_monitor
#(
	parameter int unsigned DLY_W = 7
)
(
	input  wire logic        core_clk_i,   // Sample clock
	input  wire logic        rstn_i,       // Sync reset, low
	input  wire logic [15:0] addr_i,       // Register address
	input  wire logic [7:0]  wdata_i,      // Write data
	input  wire logic        wr_i,         // Write strobe
	input  wire logic        rd_i,         // Read strobe
	output logic      [7:0]  rdata_o,      // Read data, next cycle
	input  wire logic        sysref_i,     // Alignment pulse level
	input  wire logic        align_i,      // Expected capture instant
	input  wire logic [3:0]  div_phase_i,  // Live divider phase
	input  wire logic [3:0]  setup_i,      // Setup window monitor
	input  wire logic [3:0]  hold_i,       // Hold window monitor
	output logic             div_reset_o,  // Divider reset pulse
	output logic             link_down_o,  // Link drop pulse
	output logic             ts_mark_o,    // Timestamped sample pulse
	output logic             irq_o         // Level interrupt
);

	// Software registers
	logic [7:0]               ctrl1_r;
	logic [7:0]               ctrl2_r;
	logic [7:0]               ctrl3_r;
	logic [7:0]               ts_delay_r;
	logic [7:0]               sync_r;
	logic [scm_pkg::IRQ_W-1:0] irq_stat_r;
	logic [scm_pkg::IRQ_W-1:0] irq_mask_r;

	// Captured state
	logic [3:0] setup_r;
	logic [3:0] hold_r;
	logic [3:0] phase_r;
	logic [7:0] count_r;
	logic [7:0] count_nxt;

	scm_cap_if cap_if ();

	// Address match helper
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	// Write decode
	wire logic wr_ctrl1  = wr_i && hit(addr_i, scm_pkg::ADDR_CTRL1);
	wire logic wr_ctrl2  = wr_i && hit(addr_i, scm_pkg::ADDR_CTRL2);
	wire logic wr_ctrl3  = wr_i && hit(addr_i, scm_pkg::ADDR_CTRL3);
	wire logic wr_delay  = wr_i && hit(addr_i, scm_pkg::ADDR_TS_DELAY);
	wire logic wr_sync   = wr_i && hit(addr_i, scm_pkg::ADDR_SYNC_MODE);
	wire logic wr_istat  = wr_i && hit(addr_i, scm_pkg::ADDR_IRQ_STAT);
	wire logic wr_imask  = wr_i && hit(addr_i, scm_pkg::ADDR_IRQ_MASK);

	// Control fields
	wire logic       flag_rst  = ctrl1_r[scm_pkg::CTRL1_FLAG_RST_BIT];
	wire logic       fall_sel  = ctrl1_r[scm_pkg::CTRL1_EDGE_SEL_BIT];
	wire logic [1:0] cap_mode  = ctrl1_r[scm_pkg::CTRL1_MODE_LSB +: 2];
	wire logic [3:0] ign_sel   = ctrl2_r[3:0];
	wire logic [1:0] win_pos   = ctrl3_r[scm_pkg::CTRL3_WIN_POS_LSB +: 2];
	wire logic [6:0] ts_delay  = ts_delay_r[6:0];
	wire logic       ts_mode   = (sync_r[scm_pkg::SYNC_MODE_BIT] == scm_pkg::SYNC_TIMESTAMP);
	wire logic       rearm     = wr_ctrl1 || wr_ctrl2;

	// Capture effects per mode
	wire logic       cap       = cap_if.cap;
	wire logic       div_sync  = cap && !ts_mode;
	wire logic       phase_off = (div_phase_i != scm_pkg::PHASE_ZERO);
	wire logic       ts_start  = cap && ts_mode;

	// Sticky event sources
	wire logic [scm_pkg::IRQ_W-1:0] irq_set =
		{div_sync && phase_off, cap_if.miss, cap};

	// Read mux
	wire logic [7:0] rd_mux =
		hit(addr_i, scm_pkg::ADDR_CTRL1)     ? ctrl1_r :
		hit(addr_i, scm_pkg::ADDR_CTRL2)     ? ctrl2_r :
		hit(addr_i, scm_pkg::ADDR_CTRL3)     ? ctrl3_r :
		hit(addr_i, scm_pkg::ADDR_TS_DELAY)  ? ts_delay_r :
		hit(addr_i, scm_pkg::ADDR_STATUS1)   ? {hold_r, setup_r} :
		hit(addr_i, scm_pkg::ADDR_STATUS2)   ? {4'h0, phase_r} :
		hit(addr_i, scm_pkg::ADDR_COUNT)     ? count_r :
		hit(addr_i, scm_pkg::ADDR_SYNC_MODE) ? sync_r :
		hit(addr_i, scm_pkg::ADDR_IRQ_STAT)  ? {5'h00, irq_stat_r} :
		hit(addr_i, scm_pkg::ADDR_IRQ_MASK)  ? {5'h00, irq_mask_r} :
		8'h00;

	// Counter next value, wraps by width
	assign count_nxt = flag_rst ? 8'h00 : (cap ? count_r + 8'h01 : count_r);

	assign irq_o = |(irq_stat_r & irq_mask_r);

	// Edge qualification and N-shot sequencing
	scm_sysref_edge u_edge
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.sysref_i   (sysref_i),
		.align_i    (align_i),
		.fall_sel_i (fall_sel),
		.mode_i     (cap_mode),
		.window_i   (win_pos),
		.ignore_i   (ign_sel),
		.rearm_i    (rearm),
		.cap_if     (cap_if.src)
	);

	// Timestamp delay line
	scm_ts_delay #(.DLY_W(DLY_W)) u_delay
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.start_i    (ts_start),
		.delay_i    (ts_delay[DLY_W-1:0]),
		.fire_o     (ts_mark_o)
	);

	// Control registers
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			ctrl1_r    <= scm_pkg::REG_RST;
			ctrl2_r    <= scm_pkg::REG_RST;
			ctrl3_r    <= scm_pkg::REG_RST;
			ts_delay_r <= scm_pkg::REG_RST;
			sync_r     <= scm_pkg::REG_RST;
			irq_mask_r <= '0;
		end
		else
		begin
			if (wr_ctrl1)
				ctrl1_r <= wdata_i & scm_pkg::CTRL1_WR_MASK;
			if (wr_ctrl2)
				ctrl2_r <= wdata_i & scm_pkg::CTRL2_WR_MASK;
			if (wr_ctrl3)
				ctrl3_r <= wdata_i & scm_pkg::CTRL3_WR_MASK;
			if (wr_delay)
				ts_delay_r <= wdata_i & scm_pkg::TS_DELAY_WR_MASK;
			if (wr_sync)
				sync_r <= wdata_i & scm_pkg::SYNC_WR_MASK;
			if (wr_imask)
				irq_mask_r <= wdata_i[scm_pkg::IRQ_W-1:0];
		end
	end

	// Status capture; flag reset holds flags cleared
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			setup_r <= 4'h0;
			hold_r  <= 4'h0;
			phase_r <= 4'h0;
			count_r <= 8'h00;
		end
		else
		begin
			count_r <= count_nxt;
			if (flag_rst)
			begin
				setup_r <= 4'h0;
				hold_r  <= 4'h0;
			end
			else if (cap)
			begin
				setup_r <= setup_i;
				hold_r  <= hold_i;
			end
			if (cap)
				phase_r <= div_phase_i;
		end
	end

	// Divider and link effects only in divider-reset mode
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			div_reset_o <= 1'b0;
			link_down_o <= 1'b0;
		end
		else
		begin
			div_reset_o <= div_sync;
			link_down_o <= div_sync && phase_off;
		end
	end

	// Sticky interrupt status, set beats write-one clear
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~(wr_istat ? wdata_i[scm_pkg::IRQ_W-1:0] : '0)) | irq_set;
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= rd_i ? rd_mux : 8'h00;
	end

	property p_ts_delay3;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ts_start && ts_delay == 7'h03) ##1 (!ts_start && !wr_delay) [*3] |=> ts_mark_o;
	endproperty
	a_ts_delay3: assert property (p_ts_delay3) else $error("timestamp delay wrong");

	property p_status_latch;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && !flag_rst) |=> ({hold_r, setup_r} == {$past(hold_i), $past(setup_i)});
	endproperty
	a_status_latch: assert property (p_status_latch) else $error("status not latched");

	property p_phase_latch;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cap |=> (phase_r == $past(div_phase_i));
	endproperty
	a_phase_latch: assert property (p_phase_latch) else $error("phase not recorded");

	property p_count_inc;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && !flag_rst) |=> (count_r == $past(count_r) + 8'h01);
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter did not step");

	property p_flag_clear;
		@(posedge core_clk_i) disable iff (!rstn_i)
		flag_rst |=> (count_r == 8'h00 && setup_r == 4'h0 && hold_r == 4'h0);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag reset did not clear");

	property p_div_reset;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && !ts_mode) |=> div_reset_o;
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider reset missing");

	property p_link_down;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && !ts_mode && phase_off) |=> (link_down_o && div_reset_o);
	endproperty
	a_link_down: assert property (p_link_down) else $error("link not dropped");

	property p_ts_quiet;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(div_reset_o || link_down_o) |-> $past(cap && !ts_mode);
	endproperty
	a_ts_quiet: assert property (p_ts_quiet) else $error("timestamp mode touched dividers");

	property p_ts_mark;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && ts_mode && ts_delay == 7'h00) |=> (ts_mark_o && !div_reset_o);
	endproperty
	a_ts_mark: assert property (p_ts_mark) else $error("sample not marked");

	property p_irq_sticky;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cap |=> irq_stat_r[scm_pkg::IRQ_CAP_BIT];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("capture event lost");

	property p_cap_window;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cap |-> ($past(align_i) || ($past(cap_if.lateness) <= {1'b0, $past(win_pos)}));
	endproperty
	a_cap_window: assert property (p_cap_window) else $error("capture outside window");

	property p_miss_window;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cap_if.miss |-> (!$past(align_i) && ($past(cap_if.lateness) > {1'b0, $past(win_pos)}));
	endproperty
	a_miss_window: assert property (p_miss_window) else $error("in-window edge missed");

	property p_rd_status;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rd_i && addr_i == scm_pkg::ADDR_STATUS1) |=> (rdata_o == {$past(hold_r), $past(setup_r)});
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status read wrong");

	property p_rd_idle;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!rd_i |=> (rdata_o == 8'h00);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");

	property p_count_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!flag_rst && !cap) |=> (count_r == $past(count_r));
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("counter moved");

	property p_count_wrap;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && !flag_rst && count_r == 8'hFF) |=> (count_r == 8'h00);
	endproperty
	a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap");

	property p_phase_hold;
		@(posedge core_clk_i) disable iff (!rstn_i)
		!cap |=> (phase_r == $past(phase_r));
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved");

	property p_flags_run;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!flag_rst && !cap) |=> ({hold_r, setup_r} == $past({hold_r, setup_r}));
	endproperty
	a_flags_run: assert property (p_flags_run) else $error("status flags moved");

	property p_ts_no_div;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(cap && ts_mode) |=> (!div_reset_o && !link_down_o);
	endproperty
	a_ts_no_div: assert property (p_ts_no_div) else $error("timestamp capture hit dividers");

	property p_miss_sticky;
		@(posedge core_clk_i) disable iff (!rstn_i)
		cap_if.miss |=> irq_stat_r[scm_pkg::IRQ_MISS_BIT];
	endproperty
	a_miss_sticky: assert property (p_miss_sticky) else $error("miss event lost");

	property p_link_sticky;
		@(posedge core_clk_i) disable iff (!rstn_i)
		link_down_o |-> irq_stat_r[scm_pkg::IRQ_LINK_BIT];
	endproperty
	a_link_sticky: assert property (p_link_sticky) else $error("link event lost");

endmodule : sysref_capture_monitor

// ===== scm_sysref_src.sv
`timescale 1ns/1ps
// Far-side source of the reference boundary and the alignment pulse
module scm_sysref_src
(
	input  wire logic       core_clk_i, // Sample clock
	input  wire logic       rstn_i,     // Sync reset, low
	input  wire logic       go_i,       // Start one pulse sequence
	input  wire logic [3:0] late_i,     // Edge delay after boundary
	output logic            sysref_o,   // Alignment pulse level
	output logic            align_o,    // Reference boundary pulse
	output logic            done_o      // Sequence finished
);
	logic       busy_r;
	logic [3:0] cnt_r;
	wire        start = go_i && !busy_r;

	// Boundary at start, edge late_i cycles on, low again well before done
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			busy_r   <= 1'b0;
			cnt_r    <= 4'h0;
			sysref_o <= 1'b0;
			align_o  <= 1'b0;
			done_o   <= 1'b0;
		end
		else
		begin
			align_o <= start;
			done_o  <= busy_r && (cnt_r == late_i + 4'h6);
			if (start)
			begin
				busy_r   <= 1'b1;
				cnt_r    <= 4'h0;
				sysref_o <= (late_i == 4'h0);
			end
			else if (busy_r)
			begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r + 4'h1 == late_i)
					sysref_o <= 1'b1;
				if (cnt_r == late_i + 4'h3)
					sysref_o <= 1'b0;
				if (cnt_r == late_i + 4'h6)
					busy_r <= 1'b0;
			end
		end
	end
endmodule : scm_sysref_src

// ===== sysref_capture_monitor_test.sv
`timescale 1ns/1ps
module sysref_capture_monitor_test;
	logic        core_clk_i, rstn_i, wr_i, rd_i, go, done, sysref, align;
	logic        div_reset, link_down, ts_mark, irq;
	logic [15:0] addr_i;
	logic [7:0]  wdata_i, rdata;
	logic [3:0]  phase, setup, hold, late;
	int          miscompares, check_count, cyc, cnt_div, cnt_link, cnt_ts, ts_cyc, go_cyc, lat0;
	logic [15:0] rst_regs [10] = '{16'h0120, 16'h0121, 16'h0122, 16'h0123, 16'h0128,
		16'h0129, 16'h012A, 16'h01FF, 16'h0130, 16'h0131};

	sysref_capture_monitor uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .sysref_i(sysref),
		.align_i(align), .div_phase_i(phase), .setup_i(setup), .hold_i(hold),
		.div_reset_o(div_reset), .link_down_o(link_down), .ts_mark_o(ts_mark), .irq_o(irq));
	scm_sysref_src src (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go), .late_i(late),
		.sysref_o(sysref), .align_o(align), .done_o(done));

	// Clock generator
	initial
	begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	// Pulse counters and hang guard
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (div_reset === 1'b1) cnt_div++;
		if (link_down === 1'b1) cnt_link++;
		if (ts_mark === 1'b1)
		begin
			cnt_ts++;
			ts_cyc = cyc;
		end
		if (cyc > 12000)
		begin
			miscompares++;
			$display("unexpected at %0t: run timed out", $time);
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd

	// One boundary plus edge from the source, then let outputs settle
	task automatic send(input logic [3:0] l);
		int n = 0;
		@(posedge core_clk_i);
		go   <= 1'b1;
		late <= l;
		@(posedge core_clk_i);
		go <= 1'b0;
		#1 go_cyc = cyc;
		while (done !== 1'b1 && n < 30)
		begin
			@(posedge core_clk_i);
			#1 n++;
		end
		if (n == 30)
		begin
			miscompares++;
			$display("unexpected at %0t: source sequence hung", $time);
		end
		repeat (4) @(posedge core_clk_i);
	endtask : send

	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask : test_end

	// Main sequence
	initial
	begin
		{rstn_i, wr_i, rd_i, go} = 4'h0;
		addr_i = 16'h0000;
		wdata_i = 8'h00;
		late = 4'h0;
		{phase, setup, hold} = {4'hF, 4'hA, 4'h5};
		repeat (2) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		foreach (rst_regs[i]) rd(rst_regs[i], 8'h00);
		rd(16'h0124, 8'h00);
		wr(16'h0123, 8'hFF);
		rd(16'h0123, 8'h7F);
		wr(16'h01FF, 8'hFF);
		rd(16'h01FF, 8'h01);
		wr(16'h01FF, 8'h00);
		wr(16'h0128, 8'hFF);
		rd(16'h0128, 8'h00);
		test_end("registers");
		wr(16'h0120, 8'h02);
		send(4'h0);
		chk(8'(cnt_div), 8'h01);
		chk(8'(cnt_link), 8'h01);
		phase <= 4'h0;
		send(4'h6);
		chk(8'(cnt_div), 8'h01);
		wr(16'h0122, 8'h03);
		send(4'h1);
		chk(8'(cnt_div), 8'h02);
		chk(8'(cnt_link), 8'h01);
		wr(16'h0120, 8'h00);
		rd(16'h012A, 8'h02);
		rd(16'h0128, 8'h5A);
		rd(16'h0129, 8'h00);
		chk(8'(cnt_ts), 8'h00);
		test_end("capture");
		rd(16'h0130, 8'h07);
		chk({7'h0, irq}, 8'h00);
		wr(16'h0131, 8'h02);
		chk({7'h0, irq}, 8'h01);
		wr(16'h0130, 8'h02);
		chk({7'h0, irq}, 8'h00);
		rd(16'h0130, 8'h05);
		wr(16'h0130, 8'h05);
		rd(16'h0130, 8'h00);
		wr(16'h0120, 8'h10);
		wr(16'h0120, 8'h12);
		send(4'h0);
		wr(16'h0120, 8'h00);
		chk({7'h0, irq}, 8'h01);
		rd(16'h0130, 8'h02);
		wr(16'h0130, 8'h02);
		test_end("interrupt");
		foreach (rst_regs[i])
			if (i < 2)
			begin
				wr(16'h0120, i ? 8'h06 : 8'h00);
				send(4'h0);
			end
		rd(16'h012A, 8'h02);
		wr(16'h0121, 8'h02);
		wr(16'h0120, 8'h04);
		repeat (4) send(4'h0);
		wr(16'h0120, 8'h00);
		rd(16'h012A, 8'h03);
		test_end("modes");
		wr(16'h0120, 8'h42);
		send(4'h0);
		rd(16'h012A, 8'h00);
		rd(16'h0128, 8'h00);
		wr(16'h0120, 8'h02);
		repeat (255) send(4'h0);
		wr(16'h0120, 8'h00);
		rd(16'h012A, 8'hFF);
		wr(16'h0120, 8'h02);
		repeat (2) send(4'h0);
		wr(16'h0120, 8'h00);
		rd(16'h012A, 8'h01);
		test_end("counter");
		{cnt_div, cnt_link, cnt_ts} = {32'd0, 32'd0, 32'd0};
		phase = 4'hF;
		wr(16'h01FF, 8'h01);
		wr(16'h0123, 8'h00);
		wr(16'h0120, 8'h02);
		send(4'h0);
		lat0 = ts_cyc - go_cyc;
		chk(8'(cnt_ts), 8'h01);
		chk(8'(cnt_div + cnt_link), 8'h00);
		wr(16'h0123, 8'h05);
		send(4'h0);
		repeat (6) @(posedge core_clk_i);
		chk(8'(ts_cyc - go_cyc), 8'(lat0 + 5));
		wr(16'h0123, 8'h7F);
		send(4'h0);
		repeat (130) @(posedge core_clk_i);
		chk(8'(ts_cyc - go_cyc), 8'(lat0 + 127));
		chk(8'(cnt_ts), 8'h03);
		rd(16'h0129, 8'h0F);
		test_end("timestamp");
		print_verdict();
	end
endmodule : sysref_capture_monitor_test
